//--- clf_top.v
// Channel lowpass filter control: filtering, command engine and filter scan.
`timescale 1ns/1ps
`include "clf_map.vh"

// Function
// - Filter outputs post to data registers about 4000 times per second.
// - Each new sample is held at the filter input as a step until the next.
// - Code 0 disables; 1-7 Butterworth, 11-17 Bessel.
// - About 2 ms later command clears, or holds 0x0100 on undefined code.
// - A channel given an undefined code stores code zero.
// - Command 0x8409 copies active codes to exchange words then clears.
// - Enable map bit n is set when channel n has a nonzero code.
// - Host puts channel mask in first parameter word then writes 0x840B.
// - Scan lasts about 300 ms, masked channels freeze, command then clears.
// - After scan exchange words of masked channels hold filter identity, zero or 0xFFFF.
// - Voltage and temperature results are both filtered.
// - Host reads return latest output without disturbing the filter.
module clf_top #(
  parameter CFG_WAIT_CYC = (`CLF_CLK_HZ / 1000000) * `CLF_CFG_WAIT_US,
  parameter SCAN_CYC     = (`CLF_CLK_HZ / 1000) * `CLF_SCAN_MS,
  parameter FIFO_DEPTH   = 8
) (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output wire [15:0] reg_rdata,
  input  wire        smp_valid,
  output wire        smp_ready,
  input  wire [3:0]  smp_chan,
  input  wire        smp_temp,
  input  wire [15:0] smp_data,
  output wire        probe_en,
  output wire [3:0]  probe_sel,
  input  wire [15:0] probe_id,
  output wire        post_strobe
);

  localparam POST_CYC  = `CLF_CLK_HZ / `CLF_POST_HZ;
  localparam DWELL_CYC = SCAN_CYC / `CLF_NCH;
  localparam [23:0] POST_LAST  = POST_CYC - 1;
  localparam [23:0] CFG_LAST   = CFG_WAIT_CYC - 1;
  localparam [23:0] DWELL_LAST = DWELL_CYC - 1;
  localparam ACC_W = 16 + `CLF_FRAC;
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CFG  = 2'b01;
  localparam [1:0] ST_SCAN = 2'b10;

  // Returns nonzero for a defined filter select code.
  function code_ok;
    input [15:0] c;
    begin
      code_ok = (c == `CLF_CODE_OFF) ||
                (c >= `CLF_BW_FIRST && c <= `CLF_BW_LAST) ||
                (c >= `CLF_BS_FIRST && c <= `CLF_BS_LAST);
    end
  endfunction

  // Smoothing shift for a code; the pole is set by the corner frequency.
  function [3:0] code_shift;
    input [4:0] c;
    begin
      case (c)
        5'h01, 5'h0B: code_shift = 4'h9;
        5'h02, 5'h0C: code_shift = 4'h8;
        5'h03, 5'h0D: code_shift = 4'h7;
        5'h04, 5'h0E: code_shift = 4'h6;
        5'h05, 5'h0F: code_shift = 4'h5;
        5'h06, 5'h10: code_shift = 4'h4;
        default:      code_shift = 4'h3;
      endcase
    end
  endfunction

  reg [15:0]      x_mem [0:15];
  reg [ACC_W-1:0] acc_mem [0:15];
  reg [4:0]       code_mem [0:15];
  reg [15:0]      xch_mem [0:15];

  reg [15:0] rdata_q;
  reg [15:0] cmd_q;
  reg [15:0] parm_q;
  reg [15:0] enmap_q;
  reg [15:0] enmap_d;
  reg [1:0]  state_q;
  reg [23:0] wait_q;
  reg [3:0]  scan_ch_q;
  reg [15:0] scan_mask_q;
  reg        probe_en_q;
  reg [23:0] tick_q;
  reg        post_busy_q;
  reg [3:0]  post_ch_q;
  reg        post_strobe_q;
  reg [15:0] id_s1_q;
  reg [15:0] id_s2_q;
  reg [15:0] id_s3_q;
  reg        bad_d;
  integer    i;
  integer    j;
  integer    k;

  wire [20:0] fifo_out;
  wire        fifo_valid;
  wire        fifo_pop;
  wire [3:0]  pop_ch;
  wire [15:0] pop_data;
  wire        scan_on;
  wire [ACC_W-1:0] acc_cur;
  wire [ACC_W-1:0] x_ext;
  wire [ACC_W-1:0] acc_step;
  wire [ACC_W-1:0] acc_next;

  assign reg_rdata   = rdata_q;
  assign probe_en    = probe_en_q;
  assign probe_sel   = scan_ch_q;
  assign post_strobe = post_strobe_q;
  assign scan_on     = (state_q == ST_SCAN);

  // Samples wait here while the posting pass owns the filter state.
  clf_fifo #(
    .W     (21),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .in_data   ({smp_temp, smp_chan, smp_data}),
    .out_valid (fifo_valid),
    .out_ready (~post_busy_q),
    .out_data  (fifo_out)
  );

  // Voltage and temperature words are filtered alike.
  assign pop_ch   = fifo_out[19:16];
  assign pop_data = fifo_out[15:0];
  assign fifo_pop = fifo_valid & ~post_busy_q;

  // One pole step toward the held input, arithmetic shift keeps the sign.
  assign acc_cur  = acc_mem[post_ch_q];
  assign x_ext    = {x_mem[post_ch_q], {`CLF_FRAC{1'b0}}};
  assign acc_step = ($signed(x_ext - acc_cur) >>>
                     code_shift(code_mem[post_ch_q]));
  assign acc_next = acc_cur + acc_step;

  // Channels with a nonzero code form the enable map.
  // Undefined codes waiting in the exchange words are flagged here too.
  always @* begin
    enmap_d = 16'h0000;
    bad_d   = 1'b0;
    for (i = 0; i < `CLF_NCH; i = i + 1) begin
      enmap_d[i] = (code_mem[i] != `CLF_CODE_OFF);
      bad_d      = bad_d | !code_ok(xch_mem[i]);
    end
  end

  // Three stage capture of the plug-in filter identity pins.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      id_s1_q <= 16'h0000;
      id_s2_q <= 16'h0000;
      id_s3_q <= 16'h0000;
    end else begin
      id_s1_q <= probe_id;
      id_s2_q <= id_s1_q;
      id_s3_q <= id_s2_q;
    end
  end

  // Posting timer and the sample hold memory.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_q        <= 24'h00_0000;
      post_busy_q   <= 1'b0;
      post_ch_q     <= 4'h0;
      post_strobe_q <= 1'b0;
      for (j = 0; j < `CLF_NCH; j = j + 1) begin
        x_mem[j]   <= 16'h0000;
        acc_mem[j] <= {ACC_W{1'b0}};
      end
    end else begin
      post_strobe_q <= 1'b0;
      tick_q <= (tick_q == POST_LAST) ? 24'h00_0000 : tick_q + 1'b1;
      // A new sample replaces the held value and stays until the next, except on a channel masked during a scan.
      if (fifo_pop && !(scan_on && scan_mask_q[pop_ch])) begin
        x_mem[pop_ch] <= pop_data;
      end
      // A pass over all channels starts on each timer wrap.
      if (tick_q == POST_LAST) begin
        post_busy_q <= 1'b1;
        post_ch_q   <= 4'h0;
      end else if (post_busy_q) begin
        if (code_mem[post_ch_q] == `CLF_CODE_OFF) begin
          acc_mem[post_ch_q] <= x_ext;
        end else begin
          acc_mem[post_ch_q] <= acc_next;
        end
        post_ch_q <= post_ch_q + 1'b1;
        if (post_ch_q == `CLF_NCH - 1) begin
          post_busy_q   <= 1'b0;
          post_strobe_q <= 1'b1;
        end
      end
    end
  end

  // Register reads return stored values only, never stalling the filter.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr <= `CLF_ADDR_DATA15) begin
        rdata_q <= acc_mem[reg_addr[3:0]][ACC_W-1:`CLF_FRAC];
      end else if (reg_addr == `CLF_ADDR_CMD) begin
        rdata_q <= cmd_q;
      end else if (reg_addr == `CLF_ADDR_PARM) begin
        rdata_q <= parm_q;
      end else if (reg_addr == `CLF_ADDR_ENMAP) begin
        rdata_q <= enmap_q;
      end else if (reg_addr >= `CLF_ADDR_XCH0 &&
                   reg_addr <= `CLF_ADDR_XCH15) begin
        rdata_q <= xch_mem[reg_addr[3:0]];
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  // Command engine: configure, read back and identity scan.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q       <= `CLF_CMD_IDLE;
      parm_q      <= 16'h0000;
      enmap_q     <= 16'h0000;
      state_q     <= ST_IDLE;
      wait_q      <= 24'h00_0000;
      scan_ch_q   <= 4'h0;
      scan_mask_q <= 16'h0000;
      probe_en_q  <= 1'b0;
      for (k = 0; k < `CLF_NCH; k = k + 1) begin
        code_mem[k] <= `CLF_CODE_OFF;
        xch_mem[k]  <= 16'h0000;
      end
    end else begin
      enmap_q <= enmap_d;
      case (state_q)
        ST_IDLE: begin
          if (reg_wr && reg_addr == `CLF_ADDR_PARM) begin
            parm_q <= reg_wdata;
          end
          if (reg_wr && reg_addr >= `CLF_ADDR_XCH0 &&
              reg_addr <= `CLF_ADDR_XCH15) begin
            xch_mem[reg_addr[3:0]] <= reg_wdata;
          end
          // Only an idle engine takes a new command.
          if (reg_wr && reg_addr == `CLF_ADDR_CMD) begin
            wait_q <= 24'h00_0000;
            case (reg_wdata)
              `CLF_CMD_CFG: begin
                cmd_q   <= reg_wdata;
                state_q <= ST_CFG;
              end
              `CLF_CMD_READBACK: begin
                for (k = 0; k < `CLF_NCH; k = k + 1) begin
                  xch_mem[k] <= {11'h000, code_mem[k]};
                end
                cmd_q <= `CLF_CMD_IDLE;
              end
              `CLF_CMD_SCAN: begin
                cmd_q       <= reg_wdata;
                scan_mask_q <= parm_q;
                scan_ch_q   <= 4'h0;
                probe_en_q  <= 1'b1;
                state_q     <= ST_SCAN;
              end
              default: begin
                cmd_q <= `CLF_CMD_IDLE;
              end
            endcase
          end
        end
        ST_CFG: begin
          wait_q <= wait_q + 1'b1;
          if (wait_q == CFG_LAST) begin
            for (k = 0; k < `CLF_NCH; k = k + 1) begin
              if (code_ok(xch_mem[k])) begin
                code_mem[k] <= xch_mem[k][4:0];
              end else begin
                code_mem[k] <= `CLF_CODE_OFF;
              end
            end
            cmd_q   <= bad_d ? `CLF_CMD_ERR : `CLF_CMD_IDLE;
            state_q <= ST_IDLE;
          end
        end
        ST_SCAN: begin
          wait_q <= wait_q + 1'b1;
          if (wait_q == DWELL_LAST) begin
            wait_q <= 24'h00_0000;
            if (scan_mask_q[scan_ch_q]) begin
              // A settled pin word is the identity, else unrecognised.
              xch_mem[scan_ch_q] <= (id_s2_q == id_s3_q) ?
                                    id_s3_q : `CLF_ID_UNKNOWN;
            end
            // The probe stays on the last channel once the scan ends.
            if (scan_ch_q == `CLF_NCH - 1) begin
              probe_en_q <= 1'b0;
              cmd_q      <= `CLF_CMD_IDLE;
              state_q    <= ST_IDLE;
            end else begin
              scan_ch_q <= scan_ch_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- clf_map.vh
// Constants for the channel lowpass filter control block.
`ifndef CLF_MAP_VH
`define CLF_MAP_VH

`define CLF_CLK_HZ        10000000
`define CLF_POST_HZ       4000
`define CLF_CFG_WAIT_US   2000
`define CLF_SCAN_MS       300
`define CLF_NCH           16

`define CLF_ADDR_DATA0    8'h00
`define CLF_ADDR_DATA15   8'h0F
`define CLF_ADDR_CMD      8'h10
`define CLF_ADDR_PARM     8'h11
`define CLF_ADDR_ENMAP    8'h12
`define CLF_ADDR_XCH0     8'h80
`define CLF_ADDR_XCH15    8'h8F

`define CLF_CMD_IDLE      16'h0000
`define CLF_CMD_CFG       16'h8408
`define CLF_CMD_READBACK  16'h8409
`define CLF_CMD_SCAN      16'h840B
`define CLF_CMD_ERR       16'h0100

`define CLF_ID_NONE       16'h0000
`define CLF_ID_UNKNOWN    16'hFFFF

`define CLF_CODE_OFF      5'h00
`define CLF_BW_FIRST      5'h01
`define CLF_BW_LAST       5'h07
`define CLF_BS_FIRST      5'h0B
`define CLF_BS_LAST       5'h11

`define CLF_FRAC          8

`endif

//--- clf_fifo.v
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module clf_fifo #(
  parameter W     = 21,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire         core_clk,
  input  wire         nrst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  reg          nfull_q;
  reg          empty_q;
  wire         push;
  wire         pop;
  reg [AW:0]   cnt_d;

  assign push      = in_valid & nfull_q;
  assign pop       = out_ready & ~empty_q;
  assign in_ready  = nfull_q;
  assign out_valid = ~empty_q;
  assign out_data  = mem[rp_q];

  // Next fill level from the push and pop of this cycle.
  always @* begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Pointers and registered full and empty flags.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q    <= {AW{1'b0}};
      rp_q    <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      nfull_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH - 1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH - 1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      cnt_q   <= cnt_d;
      nfull_q <= (cnt_d != DEPTH);
      empty_q <= (cnt_d == {(AW+1){1'b0}});
    end
  end

  // Storage is written without reset.
  always @(posedge core_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

endmodule

//--- clf_top_properties.sv
// Port checks for the filter control block, bound into its top.
`timescale 1ns/1ps
module clf_checker #(
  parameter SCAN_CYC = 320
) (
  input wire        core_clk,
  input wire        nrst,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        probe_en,
  input wire [3:0]  probe_sel,
  input wire        post_strobe
);
  localparam DWELL = SCAN_CYC / 16;
  reg [11:0] gap_q;
  reg        seen_q;
  reg [31:0] dwell_q;
  reg [3:0]  sel_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Counts cycles between posting passes and cycles spent on each channel.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_q   <= 12'h000;
      seen_q  <= 1'b0;
      dwell_q <= 32'h0000_0000;
      sel_q   <= 4'h0;
    end else begin
      gap_q   <= post_strobe ? 12'h000 : gap_q + 12'h001;
      seen_q  <= seen_q | post_strobe;
      dwell_q <= !probe_en ? 32'h0000_0000 : (probe_sel != sel_q) ?
                 32'h0000_0001 : dwell_q + 32'h0000_0001;
      sel_q   <= probe_sel;
    end
  end

  // The probe moves on to another channel during a scan.
  sequence s_probe_move;
    probe_en && $past(probe_en) && probe_sel != sel_q;
  endsequence

  a_post_pulse: assert property (
    post_strobe |=> !post_strobe)
    else $error("posting strobe longer than one cycle");
  a_post_period: assert property (
    post_strobe && seen_q |-> gap_q == 12'h9C3)
    else $error("posting passes not 2500 cycles apart");
  a_rdata_hold: assert property (
    !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_scan_start: assert property (
    $rose(probe_en) |-> probe_sel == 4'h0)
    else $error("scan did not start at channel zero");
  a_probe_idle: assert property (
    !probe_en |-> $stable(probe_sel))
    else $error("probe channel moved outside a scan");
  a_probe_step: assert property (
    s_probe_move |-> probe_sel == sel_q + 4'h1)
    else $error("probe skipped a channel");
  a_probe_dwell: assert property (
    s_probe_move |-> dwell_q == DWELL)
    else $error("probe dwell length wrong");
  a_scan_end: assert property (
    $fell(probe_en) |-> probe_sel == 4'hF)
    else $error("scan ended before the last channel");
endmodule

bind clf_top clf_checker #(.SCAN_CYC(SCAN_CYC)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .probe_en(probe_en), .probe_sel(probe_sel),
  .post_strobe(post_strobe)
);

//--- clf_host.sv
// Register-bus host model that writes and reads single words.
`timescale 1ns/1ps
module clf_host (
  input  wire        core_clk,
  output reg  [7:0]  reg_addr,
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [15:0] reg_wdata,
  input  wire [15:0] reg_rdata
);
  // The bus rests idle until the first access.
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One-cycle write; callers put codes and mask ahead of the command.
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
    end
  endtask

  // One-cycle read; data is taken once the registered answer has landed.
  task rd(input [7:0] a, output [15:0] d);
    begin
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd   = 1'b0;
      d        = reg_rdata;
    end
  endtask
endmodule

//--- clf_top_tb.sv
// Self-checking bench: register model, sample source and identity pins.
`timescale 1ns/1ps
module clf_top_tb;
  reg         core_clk;
  reg         nrst;
  wire [7:0]  reg_addr;
  wire        reg_wr;
  wire        reg_rd;
  wire [15:0] reg_wdata;
  wire [15:0] reg_rdata;
  reg         smp_valid;
  wire        smp_ready;
  reg  [3:0]  smp_chan;
  reg         smp_temp;
  reg  [15:0] smp_data;
  wire        probe_en;
  wire [3:0]  probe_sel;
  reg  [15:0] probe_id;
  wire        post_strobe;
  integer     n_mismatch;
  integer     num_checks;
  integer     seed;
  integer     cyc;
  integer     i;
  integer     t0;
  integer     err;
  integer     am;
  integer     xm;
  integer     code_m [0:15];
  reg  [15:0] rv;
  reg  [15:0] em;
  reg  [15:0] sv;
  reg  [15:0] mask;

  clf_top #(.CFG_WAIT_CYC(20), .SCAN_CYC(320), .FIFO_DEPTH(8)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_chan(smp_chan), .smp_temp(smp_temp), .smp_data(smp_data),
    .probe_en(probe_en), .probe_sel(probe_sel), .probe_id(probe_id),
    .post_strobe(post_strobe)
  );
  clf_host i_host (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  // Free-running 10 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Cycle count whose ceiling cuts a hang short.
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 25000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end

  // Identity pins follow the probe; channel 2 is empty, 9 is unknown.
  function [15:0] pid(input [3:0] c);
    pid = (c == 4'h2) ? 16'h0000 : (c == 4'h9) ? 16'hFFFF : 16'h0050 + c;
  endfunction
  always @(negedge core_clk) probe_id <= pid(probe_sel);

  // Code a channel keeps after a configure; undefined ones become zero.
  function integer keep(input integer c);
    keep = (c <= 7 || (c >= 11 && c <= 17)) ? c : 0;
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task rchk(input [7:0] a, input [15:0] exp);
    begin
      i_host.rd(a, rv);
      chk(rv, exp);
    end
  endtask

  // Waits for the next posting strobe, bounded by one pass and a margin.
  task wait_post;
    integer k;
    begin
      k = 0;
      @(negedge core_clk);
      while (post_strobe !== 1'b1 && k < 3000) begin
        @(negedge core_clk);
        k = k + 1;
      end
      if (post_strobe !== 1'b1)
        n_mismatch = n_mismatch + 1;
    end
  endtask

  // Offers one sample and holds it until the buffer takes it.
  task send(input [3:0] ch, input t, input [15:0] d);
    integer k;
    begin
      @(negedge core_clk);
      smp_valid = 1'b1;
      smp_chan  = ch;
      smp_temp  = t;
      smp_data  = d;
      k = 0;
      while (smp_ready !== 1'b1 && k < 100) begin
        @(negedge core_clk);
        k = k + 1;
      end
      if (smp_ready !== 1'b1)
        n_mismatch = n_mismatch + 1;
      @(negedge core_clk);
      smp_valid = 1'b0;
      smp_data  = ~d;
    end
  endtask

  // Loads codes, starts a configure, tries refused writes, reads back.
  task cfg_round(input integer r);
    integer c;
    integer w;
    begin
      err = 0;
      em  = 16'h0000;
      for (c = 0; c < 16; c = c + 1) begin
        w = (r == 0) ? c : (r == 1) ? c + 16 :
            (c == 1) ? 0 : (c == 3) ? 7 : $random(seed) & 7;
        i_host.wr(8'h80 + c[7:0], w[15:0]);
        code_m[c] = keep(w);
        err = err | (code_m[c] != w);
        em[c] = (code_m[c] != 0);
      end
      i_host.wr(8'h10, 16'h8408);
      i_host.wr(8'h80, 16'h001F);
      i_host.wr(8'h10, 16'h840B);
      rchk(8'h10, 16'h8408);
      chk({15'h0000, probe_en}, 16'h0000);
      repeat (20) @(negedge core_clk);
      rchk(8'h10, err ? 16'h0100 : 16'h0000);
      rchk(8'h12, em);
      i_host.wr(8'h10, 16'h8409);
      rchk(8'h10, 16'h0000);
      for (c = 0; c < 16; c = c + 1)
        rchk(8'h80 + c[7:0], code_m[c][15:0]);
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Main sequence: reset, three configure rounds, samples, identity scan.
  initial begin
    seed       = 55;
    n_mismatch = 0;
    num_checks = 0;
    cyc        = 0;
    nrst       = 1'b0;
    smp_valid  = 1'b0;
    smp_chan   = 4'h0;
    smp_temp   = 1'b0;
    smp_data   = 16'h0000;
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    rchk(8'h12, 16'h0000);
    rchk(8'h10, 16'h0000);
    rchk(8'h20, 16'h0000);
    for (i = 0; i < 3; i = i + 1)
      cfg_round(i);
    wait_post;
    sv = $random(seed);
    send(4'h1, 1'b1, sv);
    send(4'h3, 1'b0, sv);
    wait_post;
    t0 = cyc;
    wait_post;
    chk(16'(cyc - t0), 16'h09C4);
    rchk(8'h01, sv);
    // Channel 3 runs code 7, a shift of 3, and has seen two passes.
    xm = $signed({sv, 8'h00});
    am = 0;
    am = am + ((xm - am) >>> 3);
    am = am + ((xm - am) >>> 3);
    em = am >>> 8;
    rchk(8'h03, em);
    mask = $random(seed) | 16'h0206;
    i_host.wr(8'h11, mask);
    i_host.wr(8'h10, 16'h840B);
    send(4'h1, 1'b0, ~sv);
    i = 0;
    while (probe_en !== 1'b0 && i < 400) begin
      @(negedge core_clk);
      i = i + 1;
    end
    if (probe_en !== 1'b0)
      n_mismatch = n_mismatch + 1;
    rchk(8'h10, 16'h0000);
    for (i = 0; i < 16; i = i + 1)
      rchk(8'h80 + i[7:0], mask[i] ? pid(i[3:0]) : code_m[i][15:0]);
    wait_post;
    wait_post;
    rchk(8'h01, sv);
    finish_test;
  end
endmodule
